//--- shared/scss_consts.svh
// Purpose: Offsets, fields, reset values and timing counts
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef SCSS_CONSTS_SVH
`define SCSS_CONSTS_SVH

// Register byte offsets
`define SCSS_OFS_OSC_CTRL 8'h00
`define SCSS_OFS_CLK_DIV 8'h04
`define SCSS_OFS_IRQ_STAT 8'h08
`define SCSS_OFS_IRQ_MASK 8'h0C

// Oscillator control fields
`define SCSS_CUR_LSB 12
`define SCSS_NEW_LSB 8
`define SCSS_BIT_CLK_LOCK 7
`define SCSS_BIT_PLL_LOCK 5
`define SCSS_BIT_FAIL 3
`define SCSS_BIT_SEC_EN 1
`define SCSS_BIT_SWITCH 0

// Clock divisor fields
`define SCSS_DIV_LSB 8
`define SCSS_DIV_RST 3'h0
`define SCSS_DIV16_CODE 3'h4

// Interrupt bits
`define SCSS_IRQ_FAIL 0
`define SCSS_IRQ_DONE 1
`define SCSS_IRQ_W 2

// Timing
`define SCSS_FAIL_WINDOW 4
`define SCSS_APB_ERR_DATA 32'h0000_0000

`endif

//--- shared/scss_pkg.sv
// Purpose: Selector types
// Assumes: Nothing
// Notes: Source codes are the select-field encodings
`default_nettype none
package scss_pkg;

    typedef enum logic [2:0] {
        SRC_FRC = 3'b000,
        SRC_FRC_PLL = 3'b001,
        SRC_PRI = 3'b010,
        SRC_PRI_PLL = 3'b011,
        SRC_SEC = 3'b100,
        SRC_LOW_POWER_INTERNAL_OSC = 3'b101,
        SRC_FRC_DIV16 = 3'b110,
        SRC_FRC_DIVN = 3'b111
    } scss_src_t;

    typedef enum logic [1:0] {
        PRI_EXT_CLK = 2'b00,
        PRI_STD_XTAL = 2'b01,
        PRI_HS_XTAL = 2'b10,
        PRI_RSVD = 2'b11
    } scss_pri_t;

    typedef enum logic [3:0] {
        MODE_FRC = 4'b0000,
        MODE_FRC_PLL = 4'b0001,
        MODE_EC = 4'b0010,
        MODE_XT = 4'b0011,
        MODE_HS = 4'b0100,
        MODE_EC_PLL = 4'b0101,
        MODE_XT_PLL = 4'b0110,
        MODE_HS_PLL = 4'b0111,
        MODE_SEC = 4'b1000,
        MODE_LOW_POWER_INTERNAL_OSC = 4'b1001,
        MODE_FRC_DIV16 = 4'b1010,
        MODE_FRC_DIVN = 4'b1011
    } scss_mode_t;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_DRAIN = 2'b01,
        SW_ARM = 2'b10
    } scss_sw_t;

endpackage
`default_nettype wire

//--- shared/scss_div_if.sv
// Purpose: Selector to postscaler bundle
// Assumes: All signals on sys_clk
// Notes: outTick is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface scss_div_if;
    logic inTick;
    logic [2:0] code;
    logic outTick;
    modport divider (input inTick, input code, output outTick);
    modport user (output inTick, output code, input outTick);
endinterface
`default_nettype wire

//--- hw/scss_rc_divider.sv
// Purpose: Postscaler for the RC tick stream
// Assumes: inTick is a one-cycle enable on sys_clk
// Notes: A factor change mid-count acts at once: a smaller factor ends the current period early, a larger one extends it
`timescale 1ns/1ps
`default_nettype none
module scss_rc_divider (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Tick bundle
    scss_div_if.divider div
);

    logic [7:0] count;
    logic [7:0] term;

    function automatic logic [7:0] lastCount(input logic [2:0] code);
        case (code)
            3'b000: lastCount = 8'h00;
            3'b001: lastCount = 8'h01;
            3'b010: lastCount = 8'h03;
            3'b011: lastCount = 8'h07;
            3'b100: lastCount = 8'h0F;
            3'b101: lastCount = 8'h1F;
            3'b110: lastCount = 8'h3F;
            default: lastCount = 8'hFF;
        endcase
    endfunction

    assign term = lastCount(div.code);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count <= 8'h00;
        end else if (div.inTick) begin
            count <= (count >= term) ? 8'h00 : count + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            div.outTick <= 1'b0;
        end else begin
            div.outTick <= div.inTick && (count >= term);
        end
    end

endmodule
`default_nettype wire

//--- hw/scss_clock_select.sv
// Purpose: System clock source selection, switching, postscaling and fail monitoring
// Assumes: Oscillators arrive as one-cycle ticks on sys_clk
// Notes: System clock is oscTick plus a level toggled per tick
//
// Operation
// - Eight sources: RC, RC+PLL, primary, primary+PLL, secondary, LP RC, RC/16, RC/n.
// - The RC/n source is the RC postscaled by a factor from the divisor register.
// - The low-power RC tick is the watchdog and fail monitor reference.
// - At reset release the source comes from the configuration fields.
// - Erased configuration (all ones) starts on an RC-derived source.
// - Source and primary mode decode into twelve clock modes.
// - The instruction tick is the system oscillator tick divided by two.
// - Only the RC and primary ticks may feed the PLL; others bypass it.
// - Primary modes are standard crystal, high-speed crystal and external clock.
// - A fail monitor detects a dead system clock on any source but RC and LP RC, and falls back to the RC.
// - Software may switch the source at run time.
// - Source codes map 000 RC through 111 RC divide-by-n.
// - Divider codes give 1,2,4..64 and 256 at 111.
// - Primary mode codes are 10 high-speed, 01 standard, 00 external.
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "scss_consts.svh"
module scss_clock_select
    import scss_pkg::*;
#(
    parameter int FAIL_WINDOW = `SCSS_FAIL_WINDOW
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration memory fields
    input wire logic [2:0] initialSourceSelect,
    input wire logic [1:0] primaryModeSelect,
    // Oscillator ticks
    input wire logic fastRcTick,
    input wire logic primaryTick,
    input wire logic secondaryTick,
    input wire logic lowPowerTick,
    input wire logic pllTick,
    input wire logic pllLocked,
    // PLL feed
    output logic pllRefTick,
    output logic pllEnable,
    // Oscillator pin control
    output logic crystalDrive,
    output logic highSpeedGain,
    output logic secOscEnable,
    // Clock outputs
    output logic oscTick,
    output logic sysClkLevel,
    output logic instrTick,
    output logic watchdogRefTick,
    output logic failRefTick,
    output logic [3:0] clockMode,
    // Interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    scss_src_t currentSource;
    scss_src_t newSource;
    scss_src_t divSource;
    scss_pri_t primaryMode;
    scss_sw_t state;
    scss_sw_t next_state;
    logic loaded;
    logic switchReq;
    logic clockLock;
    logic secEnable;
    logic [2:0] rcDivider;
    logic [`SCSS_IRQ_W-1:0] irqStatus;
    logic [`SCSS_IRQ_W-1:0] irqMask;
    logic instrPhase;
    logic [7:0] lpCount;
    logic oldTick;
    logic newTick;
    logic selTick;
    logic commit;
    logic failEvent;
    logic wrEn;
    logic rdSetup;
    logic [31:0] rdData;

    scss_div_if rcDiv ();

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic usesPll(input scss_src_t s);
        usesPll = (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
    endfunction

    function automatic logic tickOf(input scss_src_t s, input logic fast_internal_rc_osc, pri, sec,
                                    lp, pll, div);
        case (s)
            SRC_FRC: tickOf = fast_internal_rc_osc;
            SRC_FRC_PLL: tickOf = pll;
            SRC_PRI: tickOf = pri;
            SRC_PRI_PLL: tickOf = pll;
            SRC_SEC: tickOf = sec;
            SRC_LOW_POWER_INTERNAL_OSC: tickOf = lp;
            default: tickOf = div;
        endcase
    endfunction

    function automatic logic isPrimary(input scss_src_t s);
        isPrimary = (s == SRC_PRI) || (s == SRC_PRI_PLL);
    endfunction

    function automatic scss_mode_t modeOf(input scss_src_t s, input scss_pri_t p);
        case (s)
            SRC_FRC: modeOf = MODE_FRC;
            SRC_FRC_PLL: modeOf = MODE_FRC_PLL;
            SRC_PRI: modeOf = (p == PRI_HS_XTAL) ? MODE_HS :
                              (p == PRI_STD_XTAL) ? MODE_XT : MODE_EC;
            SRC_PRI_PLL: modeOf = (p == PRI_HS_XTAL) ? MODE_HS_PLL :
                                  (p == PRI_STD_XTAL) ? MODE_XT_PLL : MODE_EC_PLL;
            SRC_SEC: modeOf = MODE_SEC;
            SRC_LOW_POWER_INTERNAL_OSC: modeOf = MODE_LOW_POWER_INTERNAL_OSC;
            SRC_FRC_DIV16: modeOf = MODE_FRC_DIV16;
            default: modeOf = MODE_FRC_DIVN;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Configuration capture

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            loaded <= 1'b0;
            primaryMode <= PRI_EXT_CLK;
        end else if (!loaded) begin
            loaded <= 1'b1;
            primaryMode <= scss_pri_t'(primaryModeSelect);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Postscaler and tick selection

    // Divider follows the target while arming
    assign divSource = (state == SW_ARM) ? newSource : currentSource;
    assign rcDiv.code = (divSource == SRC_FRC_DIV16) ? `SCSS_DIV16_CODE : rcDivider;
    assign rcDiv.inTick = fastRcTick;

    scss_rc_divider scss_rc_divider_inst (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .div(rcDiv)
    );

    assign oldTick = tickOf(currentSource, fastRcTick, primaryTick, secondaryTick,
                            lowPowerTick, pllTick, rcDiv.outTick);
    assign newTick = tickOf(newSource, fastRcTick, primaryTick, secondaryTick,
                            lowPowerTick, pllTick, rcDiv.outTick);

    ////////////////////////////////////////////////////////////////////////////
    // Switch sequencer

    // Park low, then restart on a new edge
    always_comb begin
        next_state = state;
        selTick = 1'b0;
        case (state)
            SW_IDLE: begin
                selTick = oldTick;
                if (switchReq && !clockLock && loaded) begin
                    next_state = SW_DRAIN;
                end
            end
            SW_DRAIN: begin
                selTick = oldTick;
                if (sysClkLevel == oldTick) begin
                    next_state = SW_ARM;
                end
            end
            SW_ARM: begin
                selTick = newTick;
                if (newTick) begin
                    next_state = SW_IDLE;
                end
            end
            default: begin
                next_state = SW_IDLE;
            end
        endcase
    end

    assign commit = (state == SW_ARM) && newTick;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= SW_IDLE;
        end else if (failEvent) begin
            state <= SW_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            currentSource <= SRC_FRC;
        end else if (!loaded) begin
            // Erased fields decode to an RC source
            currentSource <= scss_src_t'(initialSourceSelect);
        end else if (failEvent) begin
            currentSource <= SRC_FRC;
        end else if (commit) begin
            currentSource <= newSource;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock outputs

    // Level toggles only on selected ticks
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            oscTick <= 1'b0;
            sysClkLevel <= 1'b0;
        end else begin
            oscTick <= selTick && loaded;
            if (selTick && loaded) begin
                sysClkLevel <= !sysClkLevel;
            end
        end
    end

    // Instruction tick every second oscillator tick
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            instrPhase <= 1'b0;
            instrTick <= 1'b0;
        end else begin
            instrTick <= oscTick && instrPhase;
            if (oscTick) begin
                instrPhase <= !instrPhase;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            watchdogRefTick <= 1'b0;
            failRefTick <= 1'b0;
        end else begin
            watchdogRefTick <= lowPowerTick;
            failRefTick <= lowPowerTick;
        end
    end

    // PLL fed from RC or primary only
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pllRefTick <= 1'b0;
            pllEnable <= 1'b0;
        end else begin
            pllEnable <= usesPll(currentSource) || usesPll(newSource);
            pllRefTick <= (usesPll(divSource) || usesPll(currentSource)) &&
                          (isPrimary(divSource) ? primaryTick : fastRcTick);
        end
    end

    // Crystal drive only in crystal modes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            crystalDrive <= 1'b0;
            highSpeedGain <= 1'b0;
            secOscEnable <= 1'b0;
            clockMode <= MODE_FRC;
        end else begin
            crystalDrive <= (isPrimary(currentSource) || isPrimary(newSource)) &&
                            (primaryMode == PRI_STD_XTAL || primaryMode == PRI_HS_XTAL);
            highSpeedGain <= primaryMode == PRI_HS_XTAL;
            secOscEnable <= secEnable || currentSource == SRC_SEC || newSource == SRC_SEC;
            clockMode <= modeOf(currentSource, primaryMode);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fail monitor

    // Cannot watch the RC that is its own reference
    assign failEvent = loaded && currentSource != SRC_LOW_POWER_INTERNAL_OSC && currentSource != SRC_FRC &&
                       lowPowerTick && lpCount == 8'(FAIL_WINDOW - 1);

    // Reference ticks without a system tick
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lpCount <= 8'h00;
        end else if (selTick || failEvent) begin
            lpCount <= 8'h00;
        end else if (lowPowerTick && lpCount != 8'hFF) begin
            lpCount <= lpCount + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    assign wrEn = psel && penable && pwrite;
    assign rdSetup = psel && !penable && !pwrite;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            newSource <= SRC_FRC;
            clockLock <= 1'b0;
            secEnable <= 1'b0;
        end else if (!loaded) begin
            newSource <= scss_src_t'(initialSourceSelect);
        end else if (wrEn && paddr == `SCSS_OFS_OSC_CTRL) begin
            if (state == SW_IDLE) begin
                newSource <= scss_src_t'(pwdata[`SCSS_NEW_LSB +: 3]);
            end
            // Lock holds until reset
            clockLock <= clockLock || pwdata[`SCSS_BIT_CLK_LOCK];
            secEnable <= pwdata[`SCSS_BIT_SEC_EN];
        end else if (failEvent) begin
            newSource <= SRC_FRC;
        end
    end

    // Request set by software, cleared on completion
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            switchReq <= 1'b0;
        end else if (wrEn && paddr == `SCSS_OFS_OSC_CTRL && pwdata[`SCSS_BIT_SWITCH]) begin
            switchReq <= 1'b1;
        end else if (commit || failEvent) begin
            switchReq <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rcDivider <= `SCSS_DIV_RST;
        end else if (wrEn && paddr == `SCSS_OFS_CLK_DIV) begin
            rcDivider <= pwdata[`SCSS_DIV_LSB +: 3];
        end
    end

    // Sticky events, set wins over write-one-to-clear
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irqStatus <= '0;
        end else begin
            if (wrEn && paddr == `SCSS_OFS_IRQ_STAT) begin
                irqStatus <= irqStatus & ~pwdata[`SCSS_IRQ_W-1:0];
            end else if (wrEn && paddr == `SCSS_OFS_OSC_CTRL && pwdata[`SCSS_BIT_FAIL]) begin
                irqStatus[`SCSS_IRQ_FAIL] <= 1'b0;
            end
            if (failEvent) begin
                irqStatus[`SCSS_IRQ_FAIL] <= 1'b1;
            end
            if (commit) begin
                irqStatus[`SCSS_IRQ_DONE] <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irqMask <= '0;
        end else if (wrEn && paddr == `SCSS_OFS_IRQ_MASK) begin
            irqMask <= pwdata[`SCSS_IRQ_W-1:0];
        end
    end

    assign irq = |(irqStatus & irqMask);

    always_comb begin
        rdData = 32'h0000_0000;
        case (paddr)
            `SCSS_OFS_OSC_CTRL: begin
                rdData[`SCSS_CUR_LSB +: 3] = currentSource;
                rdData[`SCSS_NEW_LSB +: 3] = newSource;
                rdData[`SCSS_BIT_CLK_LOCK] = clockLock;
                rdData[`SCSS_BIT_PLL_LOCK] = pllLocked && usesPll(currentSource);
                rdData[`SCSS_BIT_FAIL] = irqStatus[`SCSS_IRQ_FAIL];
                rdData[`SCSS_BIT_SEC_EN] = secEnable;
                rdData[`SCSS_BIT_SWITCH] = switchReq;
            end
            `SCSS_OFS_CLK_DIV: rdData[`SCSS_DIV_LSB +: 3] = rcDivider;
            `SCSS_OFS_IRQ_STAT: rdData[`SCSS_IRQ_W-1:0] = irqStatus;
            `SCSS_OFS_IRQ_MASK: rdData[`SCSS_IRQ_W-1:0] = irqMask;
            default: rdData = `SCSS_APB_ERR_DATA;
        endcase
    end

    // Taken in setup so it comes from a flop
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (rdSetup) begin
            prdata <= rdData;
        end
    end

    assign pready = psel && penable;
    assign pslverr = psel && penable && paddr != `SCSS_OFS_OSC_CTRL &&
                     paddr != `SCSS_OFS_CLK_DIV && paddr != `SCSS_OFS_IRQ_STAT &&
                     paddr != `SCSS_OFS_IRQ_MASK;

endmodule
`default_nettype wire

//--- verif/scss_chk.sv
// Purpose: Port properties of the selector
// Assumes: One clock domain
// Notes: Watches outputs against their causes
`timescale 1ns/1ps
`default_nettype none
module scss_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Bus handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Oscillator ticks
    input wire logic fastRcTick,
    input wire logic primaryTick,
    input wire logic secondaryTick,
    input wire logic lowPowerTick,
    input wire logic pllTick,
    // Derived outputs
    input wire logic pllRefTick,
    input wire logic oscTick,
    input wire logic instrTick,
    input wire logic watchdogRefTick,
    input wire logic failRefTick,
    input wire logic [3:0] clockMode
);
    wire logic anyTick = fastRcTick | primaryTick | secondaryTick | lowPowerTick | pllTick;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////////
    a_ready_zero_wait: assert property (pready == (psel && penable))
        else $error("pready mismatch");
    a_err_in_access: assert property (pslverr |-> pready)
        else $error("stray pslverr");
    a_wdog_ref_copy: assert property (watchdogRefTick == $past(lowPowerTick))
        else $error("watchdog ref");
    a_fail_ref_copy: assert property (failRefTick == $past(lowPowerTick))
        else $error("fail ref");
    a_osc_has_cause: assert property (oscTick |-> $past(anyTick) || $past(anyTick, 2))
        else $error("uncaused osc tick");
    a_instr_after_osc: assert property (instrTick |-> $past(oscTick))
        else $error("uncaused instr tick");
    a_instr_halved: assert property (instrTick |=> !instrTick)
        else $error("instr tick doubled");
    a_mode_in_range: assert property (clockMode <= 4'b1011)
        else $error("bad clock mode");
    a_pll_feed_only: assert property (pllRefTick |-> $past(fastRcTick || primaryTick))
        else $error("bad PLL feed");
endmodule
`default_nettype wire

//--- verif/scss_clock_select_tb.sv
// Purpose: Self-checking bench
// Assumes: PLL held locked; ticks driven two cycles apart
// Notes: Tick bits: rc, primary, secondary, low-power, pll
`timescale 1ns/1ps
`default_nettype none
`include "scss_consts.svh"
module scss_clock_select_tb
    import scss_pkg::*;
;
    localparam int FW = 4;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pllLocked = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [2:0] initSrc = 3'h7;
    logic [1:0] priMode = 2'h3;
    logic [4:0] ticks = 5'h00;
    logic [31:0] rd;
    logic err;
    wire logic [31:0] prdata;
    wire logic [3:0] clockMode;
    wire logic pready, pslverr, pllRefTick, pllEnable, crystalDrive, highSpeedGain;
    wire logic secOscEnable, oscTick, sysClkLevel, instrTick, wdRef, failRef, irq;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0, oscCnt = 0, instrCnt = 0;

    scss_clock_select #(.FAIL_WINDOW(FW)) scss_clock_select_inst (
        .sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .initialSourceSelect(initSrc), .primaryModeSelect(priMode),
        .fastRcTick(ticks[0]), .primaryTick(ticks[1]), .secondaryTick(ticks[2]),
        .lowPowerTick(ticks[3]), .pllTick(ticks[4]), .pllLocked, .pllRefTick, .pllEnable,
        .crystalDrive, .highSpeedGain, .secOscEnable, .oscTick, .sysClkLevel, .instrTick,
        .watchdogRefTick(wdRef), .failRefTick(failRef), .clockMode, .irq
    );

    always #5 sys_clk = ~sys_clk;

    // Edge reads see pre-edge values
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        oscCnt <= oscCnt + int'(oscTick === 1'b1);
        instrCnt <= instrCnt + int'(instrTick === 1'b1);
        if (cyc == 30000) begin
            n_errors++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1);
        chk(32'(k), 32'h1, "wait states");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge sys_clk);
    endtask

    // Trailing wait lets derived ticks land
    task automatic pulse(input logic [4:0] m, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            ticks <= m;
            @(posedge sys_clk);
            ticks <= 5'h00;
        end
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic rst(input logic [2:0] s, input logic [1:0] p);
        @(posedge sys_clk);
        nrst <= 1'b0;
        initSrc <= s;
        priMode <= p;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_primary();
        for (int s = 2; s <= 3; s++) begin
            for (int p = 0; p <= 2; p++) begin
                rst(3'(s), 2'(p));
                apb(1'b0, `SCSS_OFS_OSC_CTRL, 32'h0);
                chk(32'(rd[14:12]), 32'(s), "start source");
                chk(32'(clockMode), 32'((s == 3 ? 5 : 2) + p), "primary mode");
                chk(32'({crystalDrive, highSpeedGain}), 32'({p != 0, p == 2}), "pins");
                chk(32'(pllEnable), 32'(s == 3), "pll use");
            end
        end
        $display("test_primary done");
    endtask

    task automatic test_erased();
        rst(3'h7, 2'h3);
        chk(32'(clockMode), 32'(MODE_FRC_DIVN), "erased mode");
        apb(1'b0, `SCSS_OFS_OSC_CTRL, 32'h0);
        chk(32'({rd[14:12], rd[10:8]}), 32'h3F, "erased fields");
        apb(1'b0, `SCSS_OFS_CLK_DIV, 32'h0);
        chk(rd, 32'h0000_0000, "div reset");
        apb(1'b0, `SCSS_OFS_IRQ_MASK, 32'h0);
        chk(rd, 32'h0000_0000, "mask reset");
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0000_0000, "unmapped data");
        chk(32'(err), 32'h1, "unmapped error");
        $display("test_erased done");
    endtask

    task automatic test_divider();
        int f, o, i;
        for (int c = 0; c < 8; c++) begin
            f = (c == 7) ? 256 : (1 << c);
            apb(1'b1, `SCSS_OFS_CLK_DIV, 32'(c) << 8);
            apb(1'b0, `SCSS_OFS_CLK_DIV, 32'h0);
            chk(rd, 32'(c) << 8, "div readback");
            pulse(5'h01, f);
            o = oscCnt;
            i = instrCnt;
            pulse(5'h01, 4 * f);
            chk(32'(oscCnt - o), 32'h4, "osc ticks");
            chk(32'(instrCnt - i), 32'h2, "instr ticks");
        end
        apb(1'b1, `SCSS_OFS_CLK_DIV, 32'h0);
        $display("test_divider done");
    endtask

    task automatic test_switch();
        logic [2:0] tgt [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
        scss_mode_t md [6] = '{MODE_FRC, MODE_FRC_PLL, MODE_SEC, MODE_LOW_POWER_INTERNAL_OSC, MODE_FRC_DIV16,
            MODE_FRC_DIVN};
        logic [2:0] prev = 3'h7;
        int k;
        apb(1'b1, `SCSS_OFS_IRQ_MASK, 32'h0000_0003);
        for (int j = 0; j < 6; j++) begin
            apb(1'b1, `SCSS_OFS_OSC_CTRL, {21'h0, tgt[j], 8'h01});
            apb(1'b0, `SCSS_OFS_OSC_CTRL, 32'h0);
            chk(32'(rd[14:12]), 32'(prev), "src before");
            k = 0;
            while (clockMode !== md[j] && k < 40) begin
                pulse((tgt[j] == 3'h5 || prev == 3'h5) ? 5'h1F : 5'h17, 1);
                k++;
            end
            apb(1'b0, `SCSS_OFS_OSC_CTRL, 32'h0);
            chk(32'({rd[14:12], rd[0]}), 32'({tgt[j], 1'b0}), "src after");
            chk(32'(clockMode), 32'(md[j]), "mode after");
            if (j == 0) begin
                chk(32'(irq), 32'h1, "done irq");
                apb(1'b1, `SCSS_OFS_IRQ_STAT, 32'h0000_0002);
                chk(32'(irq), 32'h0, "done cleared");
                apb(1'b1, `SCSS_OFS_IRQ_MASK, 32'h0000_0001);
            end
            prev = tgt[j];
        end
        chk(32'(irq), 32'h0, "done masked");
        $display("test_switch done");
    endtask

    task automatic test_fail_lock();
        pulse(5'h08, FW - 1);
        chk(32'(clockMode), 32'(MODE_FRC_DIVN), "early fail");
        pulse(5'h08, 3);
        chk(32'(clockMode), 32'(MODE_FRC), "fallback");
        apb(1'b0, `SCSS_OFS_OSC_CTRL, 32'h0);
        chk(32'({rd[14:12], rd[3], irq}), 32'h3, "fail flag");
        apb(1'b1, `SCSS_OFS_IRQ_STAT, 32'h0000_0003);
        chk(32'(irq), 32'h0, "fail cleared");
        apb(1'b1, `SCSS_OFS_OSC_CTRL, 32'h0000_0080);
        apb(1'b1, `SCSS_OFS_OSC_CTRL, 32'h0000_0583);
        pulse(5'h1F, 10);
        chk(32'(clockMode), 32'(MODE_FRC), "locked");
        apb(1'b0, `SCSS_OFS_OSC_CTRL, 32'h0);
        chk(32'({rd[14:12], rd[7], rd[1:0], secOscEnable}), 32'hF, "pending");
        $display("test_fail_lock done");
    endtask

    task automatic give_verdict();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst(3'h7, 2'h3);
        test_primary();
        test_erased();
        test_divider();
        test_switch();
        test_fail_lock();
        give_verdict();
    end
endmodule

bind scss_clock_select scss_chk scss_chk_inst (
    .sys_clk, .nrst, .psel, .penable, .pready, .pslverr, .fastRcTick, .primaryTick,
    .secondaryTick, .lowPowerTick, .pllTick, .pllRefTick, .oscTick, .instrTick,
    .watchdogRefTick, .failRefTick, .clockMode
);
`default_nettype wire
